// ===== rtl/ipr_pkg.sv
// Package with register map, field layout and reset values of the priority bank
// What this block does
// RQ1: Each source has a 3-bit read/write priority field; seven is the highest level.
// RQ2: Code one is lowest enabled level; codes two to six map to levels two to six.
// RQ3: Code zero disables the source so it never competes for service; this block does not decode code zero, only passes it on.
// RQ4: Bits outside the priority fields are unimplemented and read as zero.
// RQ5: Reset loads binary 100, level four, into every priority field.
// RQ6: First register holds UART1 receive priority in bits 14 to 12.
// RQ7: First register holds SPI1 event priority in bits 10 to 8.
// RQ8: First register holds SPI1 error priority in bits 6 to 4.
// RQ9: First register holds Timer3 priority in bits 2 to 0.
// RQ10: Second register holds DMA channel 1 priority in bits 10 to 8; 15-11 unused.
// RQ11: Second register holds ADC1 done priority in bits 6 to 4.
// RQ12: Second register holds UART1 transmit priority in bits 2 to 0.
// RQ13: Third register holds pin change priority in bits 14 to 12.
// RQ14: Third register holds comparator priority in bits 10 to 8.
// RQ15: Third register holds I2C1 master in bits 6-4, slave in bits 2-0.
// RQ16: Fourth register holds capture channel 8 priority in bits 14 to 12.
// RQ17: Fourth register holds capture channel 7 priority in bits 10 to 8.
// RQ18: Fourth register holds external interrupt 1 in bits 2-0; bits 7-3 unused.
// RQ19: Writes to unimplemented bits are ignored; only implemented fields update.
// RQ20: Every priority field drives its own continuous 3-bit output.
package ipr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] IPR_OFS_CTRL2 = 4'h0;
    localparam logic [3:0] IPR_OFS_CTRL3 = 4'h4;
    localparam logic [3:0] IPR_OFS_CTRL4 = 4'h8;
    localparam logic [3:0] IPR_OFS_CTRL5 = 4'hC;
    // ****************************************
    // Field layout and reset
    // ****************************************
    localparam int IPR_POS_F3 = 12;
    localparam int IPR_POS_F2 = 8;
    localparam int IPR_POS_F1 = 4;
    localparam int IPR_POS_F0 = 0;
    localparam logic [15:0] IPR_MASK_CTRL2 = 16'h7777;
    localparam logic [15:0] IPR_MASK_CTRL3 = 16'h0777;
    localparam logic [15:0] IPR_MASK_CTRL4 = 16'h7777;
    localparam logic [15:0] IPR_MASK_CTRL5 = 16'h7707;
    localparam logic [2:0] IPR_PRIO_RESET = 3'h4;
    localparam logic [2:0] IPR_PRIO_OFF = 3'h0;
    localparam logic [1:0] IPR_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] IPR_HSIZE_WORD = 3'h2;
endpackage

// ===== rtl/ipr_priority_bank.sv
// Four priority control registers behind an AHB-Lite slave
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module ipr_priority_bank (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [2:0] uart1_rx_prio,
    output logic [2:0] spi1_event_prio,
    output logic [2:0] spi1_error_prio,
    output logic [2:0] timer3_prio,
    output logic [2:0] dma_ch1_done_prio,
    output logic [2:0] adc1_done_prio,
    output logic [2:0] uart1_tx_prio,
    output logic [2:0] pin_change_prio,
    output logic [2:0] comparator_prio,
    output logic [2:0] i2c1_master_prio,
    output logic [2:0] i2c1_slave_prio,
    output logic [2:0] capture_ch8_prio,
    output logic [2:0] capture_ch7_prio,
    output logic [2:0] ext_irq1_prio
);
    // ****************************************
    // Register storage
    // ****************************************
    logic [15:0] prioReg [4];
    logic wrPending;
    logic [1:0] wrIndex;
    logic takeXfer;
    logic mappedAddr;
    logic [15:0] next_rdWord;

    function automatic logic [15:0] ipr_mask_of(input logic [1:0] idx);
        logic [15:0] m;
        m = ipr_pkg::IPR_MASK_CTRL2;
        if (idx == 2'h1) begin
            m = ipr_pkg::IPR_MASK_CTRL3;
        end else if (idx == 2'h2) begin
            m = ipr_pkg::IPR_MASK_CTRL4;
        end else if (idx == 2'h3) begin
            m = ipr_pkg::IPR_MASK_CTRL5;
        end
        return m;
    endfunction

    function automatic logic [15:0] ipr_reset_of(input logic [1:0] idx);
        logic [15:0] r;
        r = {4{1'b0, ipr_pkg::IPR_PRIO_RESET}} & ipr_mask_of(idx);
        return r;
    endfunction

    // ****************************************
    // Bus slave
    // ****************************************
    // Single-word transfers only; every access answers with zero wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign takeXfer = hsel && hready && (htrans == ipr_pkg::IPR_HTRANS_NONSEQ);
    assign mappedAddr = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'h0);

    always_comb begin
        next_rdWord = 16'h0000;
        if (!mappedAddr) begin
            next_rdWord = 16'h0000;
        end else if (haddr[3:0] == ipr_pkg::IPR_OFS_CTRL2) begin
            next_rdWord = prioReg[0];
        end else if (haddr[3:0] == ipr_pkg::IPR_OFS_CTRL3) begin
            next_rdWord = prioReg[1];
        end else if (haddr[3:0] == ipr_pkg::IPR_OFS_CTRL4) begin
            next_rdWord = prioReg[2];
        end else if (haddr[3:0] == ipr_pkg::IPR_OFS_CTRL5) begin
            next_rdWord = prioReg[3];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPending <= 1'b0;
            wrIndex <= 2'h0;
        end else if (clkEn) begin
            wrPending <= takeXfer && hwrite && mappedAddr;
            wrIndex <= haddr[3:2];
        end
    end

    // Read data is registered in the address phase; unmapped reads give zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (clkEn && takeXfer && !hwrite) begin
            hrdata <= {16'h0000, next_rdWord}; // [RQ4]
        end
    end

    // ****************************************
    // Priority registers
    // ****************************************
    for (genvar i = 0; i < 4; i++) begin : g_reg
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                prioReg[i] <= ipr_reset_of(2'(i)); // [RQ5]
            end else if (clkEn && wrPending && wrIndex == 2'(i)) begin
                prioReg[i] <= hwdata[15:0] & ipr_mask_of(2'(i)); // [RQ19] [RQ4] [RQ1]
            end
        end
    end

    // ****************************************
    // Per-source outputs
    // ****************************************
    // Codes pass straight through: 0 off, 1..7 levels; code 0 is not decoded here, only passed on
    assign uart1_rx_prio = prioReg[0][ipr_pkg::IPR_POS_F3 +: 3]; // [RQ6] [RQ20] [RQ2] [RQ3]
    assign spi1_event_prio = prioReg[0][ipr_pkg::IPR_POS_F2 +: 3]; // [RQ7]
    assign spi1_error_prio = prioReg[0][ipr_pkg::IPR_POS_F1 +: 3]; // [RQ8]
    assign timer3_prio = prioReg[0][ipr_pkg::IPR_POS_F0 +: 3]; // [RQ9]
    assign dma_ch1_done_prio = prioReg[1][ipr_pkg::IPR_POS_F2 +: 3]; // [RQ10]
    assign adc1_done_prio = prioReg[1][ipr_pkg::IPR_POS_F1 +: 3]; // [RQ11]
    assign uart1_tx_prio = prioReg[1][ipr_pkg::IPR_POS_F0 +: 3]; // [RQ12]
    assign pin_change_prio = prioReg[2][ipr_pkg::IPR_POS_F3 +: 3]; // [RQ13]
    assign comparator_prio = prioReg[2][ipr_pkg::IPR_POS_F2 +: 3]; // [RQ14]
    assign i2c1_master_prio = prioReg[2][ipr_pkg::IPR_POS_F1 +: 3]; // [RQ15]
    assign i2c1_slave_prio = prioReg[2][ipr_pkg::IPR_POS_F0 +: 3]; // [RQ15]
    assign capture_ch8_prio = prioReg[3][ipr_pkg::IPR_POS_F3 +: 3]; // [RQ16]
    assign capture_ch7_prio = prioReg[3][ipr_pkg::IPR_POS_F2 +: 3]; // [RQ17]
    assign ext_irq1_prio = prioReg[3][ipr_pkg::IPR_POS_F0 +: 3]; // [RQ18]

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    unused_bits_zero_a: assert property (((prioReg[1] & ~ipr_pkg::IPR_MASK_CTRL3) == 16'h0000) && // [RQ4]
        ((prioReg[3] & ~ipr_pkg::IPR_MASK_CTRL5) == 16'h0000))
        else $error("unimplemented bits set");
    reset_level_four_a: assert property ($fell(rst) |-> (uart1_rx_prio == 3'h4 && ext_irq1_prio == 3'h4)) // [RQ5]
        else $error("reset value wrong");
    write_lands_a: assert property (clkEn && wrPending && wrIndex == 2'h0 |=> prioReg[0] == ($past(hwdata[15:0]) & 16'h7777)) // [RQ19]
        else $error("write not stored");
    write_masked_a: assert property (clkEn && wrPending && wrIndex == 2'h3 |=> ext_irq1_prio == $past(hwdata[2:0]) && // [RQ18]
        capture_ch7_prio == $past(hwdata[10:8]))
        else $error("field write wrong");
    hold_no_write_a: assert property (!(wrPending && clkEn) |=> $stable(prioReg[2])) // [RQ1]
        else $error("register changed without write");
    read_back_a: assert property (clkEn && takeXfer && !hwrite && mappedAddr && haddr[3:0] == 4'h4 |=> // [RQ10]
        hrdata == {16'h0000, $past(prioReg[1])})
        else $error("read data wrong");
    upper_zero_a: assert property (hrdata[31:16] == 16'h0000) // [RQ4]
        else $error("upper read bits set");
    field_map_a: assert property (timer3_prio == prioReg[0][2:0] && i2c1_master_prio == prioReg[2][6:4]) // [RQ20]
        else $error("field mapping wrong");
    frozen_a: assert property (!clkEn |=> $stable(prioReg[0]) && $stable(hrdata))
        else $error("state moved while disabled");

    // ****************************************
    // Decoded hits for the checks
    // ****************************************
    // Check-only decode; keeps every property on one register and one bus phase
    logic [3:0] rdHit;
    logic [3:0] wrHit;
    assign rdHit[0] = clkEn && takeXfer && !hwrite && mappedAddr && haddr[3:0] == ipr_pkg::IPR_OFS_CTRL2;
    assign rdHit[1] = clkEn && takeXfer && !hwrite && mappedAddr && haddr[3:0] == ipr_pkg::IPR_OFS_CTRL3;
    assign rdHit[2] = clkEn && takeXfer && !hwrite && mappedAddr && haddr[3:0] == ipr_pkg::IPR_OFS_CTRL4;
    assign rdHit[3] = clkEn && takeXfer && !hwrite && mappedAddr && haddr[3:0] == ipr_pkg::IPR_OFS_CTRL5;
    assign wrHit[0] = clkEn && wrPending && wrIndex == 2'h0;
    assign wrHit[1] = clkEn && wrPending && wrIndex == 2'h1;
    assign wrHit[2] = clkEn && wrPending && wrIndex == 2'h2;
    assign wrHit[3] = clkEn && wrPending && wrIndex == 2'h3;

    // ****************************************
    // Reset values and unused bits
    // ****************************************
    reset_reg_zero_a: assert property ($fell(rst) |-> prioReg[0] == 16'h4444) // [RQ5]
        else $error("first register reset value wrong");
    reset_reg_one_a: assert property ($fell(rst) |-> prioReg[1] == 16'h0444) // [RQ5]
        else $error("second register reset value wrong");
    reset_reg_two_a: assert property ($fell(rst) |-> prioReg[2] == 16'h4444) // [RQ5]
        else $error("third register reset value wrong");
    reset_reg_three_a: assert property ($fell(rst) |-> prioReg[3] == 16'h4404) // [RQ5]
        else $error("fourth register reset value wrong");
    unused_first_zero_a: assert property ((prioReg[0] & ~ipr_pkg::IPR_MASK_CTRL2) == 16'h0000) // [RQ4]
        else $error("first register unused bits set");
    unused_third_zero_a: assert property ((prioReg[2] & ~ipr_pkg::IPR_MASK_CTRL4) == 16'h0000) // [RQ4]
        else $error("third register unused bits set");

    // ****************************************
    // Field placement
    // ****************************************
    map_uart_rx_a: assert property (uart1_rx_prio == prioReg[0][14:12]) // [RQ6]
        else $error("uart receive priority misplaced");
    map_spi_event_a: assert property (spi1_event_prio == prioReg[0][10:8]) // [RQ7]
        else $error("spi event priority misplaced");
    map_spi_error_a: assert property (spi1_error_prio == prioReg[0][6:4]) // [RQ8]
        else $error("spi error priority misplaced");
    map_timer_three_a: assert property (timer3_prio == prioReg[0][2:0]) // [RQ9]
        else $error("timer priority misplaced");
    map_dma_done_a: assert property (dma_ch1_done_prio == prioReg[1][10:8]) // [RQ10]
        else $error("dma priority misplaced");
    map_adc_done_a: assert property (adc1_done_prio == prioReg[1][6:4]) // [RQ11]
        else $error("adc priority misplaced");
    map_uart_tx_a: assert property (uart1_tx_prio == prioReg[1][2:0]) // [RQ12]
        else $error("uart transmit priority misplaced");
    map_pin_change_a: assert property (pin_change_prio == prioReg[2][14:12]) // [RQ13]
        else $error("pin change priority misplaced");
    map_comparator_a: assert property (comparator_prio == prioReg[2][10:8]) // [RQ14]
        else $error("comparator priority misplaced");
    map_i2c_master_a: assert property (i2c1_master_prio == prioReg[2][6:4]) // [RQ15]
        else $error("i2c master priority misplaced");
    map_i2c_slave_a: assert property (i2c1_slave_prio == prioReg[2][2:0]) // [RQ15]
        else $error("i2c slave priority misplaced");
    map_capture_eight_a: assert property (capture_ch8_prio == prioReg[3][14:12]) // [RQ16]
        else $error("capture eight priority misplaced");
    map_capture_seven_a: assert property (capture_ch7_prio == prioReg[3][10:8]) // [RQ17]
        else $error("capture seven priority misplaced");
    map_ext_irq_a: assert property (ext_irq1_prio == prioReg[3][2:0]) // [RQ18]
        else $error("external interrupt priority misplaced");

    // ****************************************
    // Write path per field
    // ****************************************
    wr_uart_rx_a: assert property (wrHit[0] |=> // [RQ6]
        uart1_rx_prio == $past(hwdata[14:12]))
        else $error("uart receive priority write lost");
    wr_spi_event_a: assert property (wrHit[0] |=> // [RQ7]
        spi1_event_prio == $past(hwdata[10:8]))
        else $error("spi event priority write lost");
    wr_spi_error_a: assert property (wrHit[0] |=> // [RQ8]
        spi1_error_prio == $past(hwdata[6:4]))
        else $error("spi error priority write lost");
    wr_timer_three_a: assert property (wrHit[0] |=> // [RQ9]
        timer3_prio == $past(hwdata[2:0]))
        else $error("timer priority write lost");
    wr_dma_done_a: assert property (wrHit[1] |=> // [RQ10]
        dma_ch1_done_prio == $past(hwdata[10:8]))
        else $error("dma priority write lost");
    wr_adc_done_a: assert property (wrHit[1] |=> // [RQ11]
        adc1_done_prio == $past(hwdata[6:4]))
        else $error("adc priority write lost");
    wr_uart_tx_a: assert property (wrHit[1] |=> // [RQ12]
        uart1_tx_prio == $past(hwdata[2:0]))
        else $error("uart transmit priority write lost");
    wr_pin_change_a: assert property (wrHit[2] |=> // [RQ13]
        pin_change_prio == $past(hwdata[14:12]))
        else $error("pin change priority write lost");
    wr_comparator_a: assert property (wrHit[2] |=> // [RQ14]
        comparator_prio == $past(hwdata[10:8]))
        else $error("comparator priority write lost");
    wr_i2c_master_a: assert property (wrHit[2] |=> // [RQ15]
        i2c1_master_prio == $past(hwdata[6:4]))
        else $error("i2c master priority write lost");
    wr_i2c_slave_a: assert property (wrHit[2] |=> // [RQ15]
        i2c1_slave_prio == $past(hwdata[2:0]))
        else $error("i2c slave priority write lost");
    wr_capture_eight_a: assert property (wrHit[3] |=> // [RQ16]
        capture_ch8_prio == $past(hwdata[14:12]))
        else $error("capture eight priority write lost");
    wr_capture_seven_a: assert property (wrHit[3] |=> // [RQ17]
        capture_ch7_prio == $past(hwdata[10:8]))
        else $error("capture seven priority write lost");
    wr_ext_irq_a: assert property (wrHit[3] |=> // [RQ18]
        ext_irq1_prio == $past(hwdata[2:0]))
        else $error("external interrupt priority write lost");

    // ****************************************
    // Read path per field
    // ****************************************
    rd_uart_rx_a: assert property (rdHit[0] |=> // [RQ6]
        hrdata[14:12] == $past(uart1_rx_prio))
        else $error("uart receive priority read wrong");
    rd_spi_event_a: assert property (rdHit[0] |=> // [RQ7]
        hrdata[10:8] == $past(spi1_event_prio))
        else $error("spi event priority read wrong");
    rd_spi_error_a: assert property (rdHit[0] |=> // [RQ8]
        hrdata[6:4] == $past(spi1_error_prio))
        else $error("spi error priority read wrong");
    rd_timer_three_a: assert property (rdHit[0] |=> // [RQ9]
        hrdata[2:0] == $past(timer3_prio))
        else $error("timer priority read wrong");
    rd_dma_done_a: assert property (rdHit[1] |=> // [RQ10]
        hrdata[10:8] == $past(dma_ch1_done_prio))
        else $error("dma priority read wrong");
    rd_adc_done_a: assert property (rdHit[1] |=> // [RQ11]
        hrdata[6:4] == $past(adc1_done_prio))
        else $error("adc priority read wrong");
    rd_uart_tx_a: assert property (rdHit[1] |=> // [RQ12]
        hrdata[2:0] == $past(uart1_tx_prio))
        else $error("uart transmit priority read wrong");
    rd_pin_change_a: assert property (rdHit[2] |=> // [RQ13]
        hrdata[14:12] == $past(pin_change_prio))
        else $error("pin change priority read wrong");
    rd_comparator_a: assert property (rdHit[2] |=> // [RQ14]
        hrdata[10:8] == $past(comparator_prio))
        else $error("comparator priority read wrong");
    rd_i2c_master_a: assert property (rdHit[2] |=> // [RQ15]
        hrdata[6:4] == $past(i2c1_master_prio))
        else $error("i2c master priority read wrong");
    rd_i2c_slave_a: assert property (rdHit[2] |=> // [RQ15]
        hrdata[2:0] == $past(i2c1_slave_prio))
        else $error("i2c slave priority read wrong");
    rd_capture_eight_a: assert property (rdHit[3] |=> // [RQ16]
        hrdata[14:12] == $past(capture_ch8_prio))
        else $error("capture eight priority read wrong");
    rd_capture_seven_a: assert property (rdHit[3] |=> // [RQ17]
        hrdata[10:8] == $past(capture_ch7_prio))
        else $error("capture seven priority read wrong");
    rd_ext_irq_a: assert property (rdHit[3] |=> // [RQ18]
        hrdata[2:0] == $past(ext_irq1_prio))
        else $error("external interrupt priority read wrong");
    read_back_zero_a: assert property (rdHit[0] |=> // [RQ4]
        hrdata == {16'h0000, $past(prioReg[0])})
        else $error("first register read wrong");
    read_back_two_a: assert property (rdHit[2] |=> // [RQ4]
        hrdata == {16'h0000, $past(prioReg[2])})
        else $error("third register read wrong");
    read_back_three_a: assert property (rdHit[3] |=> // [RQ4]
        hrdata == {16'h0000, $past(prioReg[3])})
        else $error("fourth register read wrong");
    unmapped_read_a: assert property (clkEn && takeXfer && !hwrite && !mappedAddr |=> // [RQ4]
        hrdata == 32'h00000000)
        else $error("unmapped read not zero");

    // ****************************************
    // Holding, freezing and refused writes
    // ****************************************
    hold_reg_zero_a: assert property (!wrHit[0] |=> $stable(prioReg[0])) // [RQ19]
        else $error("first register changed without write");
    hold_reg_one_a: assert property (!wrHit[1] |=> $stable(prioReg[1])) // [RQ19]
        else $error("second register changed without write");
    hold_reg_three_a: assert property (!wrHit[3] |=> $stable(prioReg[3])) // [RQ19]
        else $error("fourth register changed without write");
    frozen_reg_one_a: assert property (!clkEn |=> $stable(prioReg[1]))
        else $error("second register moved while disabled");
    frozen_reg_two_a: assert property (!clkEn |=> $stable(prioReg[2]))
        else $error("third register moved while disabled");
    frozen_reg_three_a: assert property (!clkEn |=> $stable(prioReg[3]))
        else $error("fourth register moved while disabled");
    unmapped_write_a: assert property (clkEn && takeXfer && hwrite && !mappedAddr |=> // [RQ19]
        !wrPending)
        else $error("unmapped write accepted");
    okay_resp_a: assert property (hreadyout && !hresp)
        else $error("bus response not okay");

    write_seen_c: cover property (clkEn && wrPending);
    read_seen_c: cover property (clkEn && takeXfer && !hwrite);
    disabled_c: cover property (uart1_rx_prio == 3'h0);
    top_level_c: cover property (ext_irq1_prio == 3'h7);
    frozen_write_c: cover property (!clkEn && takeXfer && hwrite);
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the priority register bank
`timescale 1ns/1ps
module tb_top;
    logic sysClk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout;
    logic hresp;
    logic [2:0] p [14];
    logic [15:0] obs [4];
    logic [15:0] ev [4];
    logic [3:0] ofs [4] = '{ipr_pkg::IPR_OFS_CTRL2, ipr_pkg::IPR_OFS_CTRL3, ipr_pkg::IPR_OFS_CTRL4,
        ipr_pkg::IPR_OFS_CTRL5};
    logic [15:0] msk [4] = '{16'h7777, 16'h0777, 16'h7777, 16'h7707};
    logic [15:0] pat [4] = '{16'h7210, 16'hFF53, 16'h3456, 16'h6FBF};
    int failCount = 0;
    int checkCount = 0;
    int cycles = 0;
    always #50 sysClk = ~sysClk;
    ipr_priority_bank u_dut (.sys_clk(sysClk), .rst(rst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .uart1_rx_prio(p[0]), .spi1_event_prio(p[1]),
        .spi1_error_prio(p[2]), .timer3_prio(p[3]), .dma_ch1_done_prio(p[4]), .adc1_done_prio(p[5]),
        .uart1_tx_prio(p[6]), .pin_change_prio(p[7]), .comparator_prio(p[8]), .i2c1_master_prio(p[9]),
        .i2c1_slave_prio(p[10]), .capture_ch8_prio(p[11]), .capture_ch7_prio(p[12]), .ext_irq1_prio(p[13]));
    // Outputs packed back into register layout for one compare per register
    assign obs[0] = {1'b0, p[0], 1'b0, p[1], 1'b0, p[2], 1'b0, p[3]};
    assign obs[1] = {5'h00, p[4], 1'b0, p[5], 1'b0, p[6]};
    assign obs[2] = {1'b0, p[7], 1'b0, p[8], 1'b0, p[9], 1'b0, p[10]};
    assign obs[3] = {1'b0, p[11], 1'b0, p[12], 5'h00, p[13]};
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic waitRdy();
        @(posedge sysClk);
        while (hreadyout !== 1'b1) @(posedge sysClk);
    endtask
    // Single word transfer; master holds each phase until hready is seen high
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= ipr_pkg::IPR_HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= a;
        hsize <= ipr_pkg::IPR_HSIZE_WORD;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    // Read back each register in turn and compare its per-source outputs right after
    task automatic checkBank();
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, {28'h0, ofs[i]}, 32'h0);
            chk("register", rd, {16'h0, ev[i]});
            chk("outputs", {16'h0, obs[i]}, {16'h0, ev[i]});
        end
    endtask
    task automatic writeAll(input logic [15:0] hi, input int usePat);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, {28'h0, ofs[i]}, {hi, (usePat != 0) ? pat[i] : 16'hFFFF});
            ev[i] = ((usePat != 0) ? pat[i] : 16'hFFFF) & msk[i];
        end
    endtask
    task automatic resetBank(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge sysClk);
        rst <= 1'b0;
        @(posedge sysClk);
        for (int i = 0; i < 4; i++) ev[i] = msk[i] & 16'h4444;
        checkBank();
    endtask
    task automatic giveVerdict();
        if (failCount == 0 && checkCount > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    always @(posedge sysClk) begin
        cycles++;
        if (cycles == 4000) begin
            failCount++;
            giveVerdict();
        end
    end
    initial begin
        resetBank(16);
        writeAll(16'hFFFF, 0);
        checkBank();
        writeAll(16'hA5A5, 1);
        checkBank();
        xfer(1'b1, 32'h00000010, 32'hFFFFFFFF);
        xfer(1'b0, 32'h00000010, 32'h0);
        chk("unmapped", rd, 32'h0);
        checkBank();
        clkEn <= 1'b0;
        xfer(1'b1, {28'h0, ofs[0]}, 32'h0);
        clkEn <= 1'b1;
        checkBank();
        resetBank(2);
        giveVerdict();
    end
endmodule
